// file: inc/bsu_pkg.sv
// constants and types shared by the packed-BCD subtract unit
// Functional notes
// - word subtract writes the 4-digit BCD difference, 10's complement when negative
// - 10's complement means each digit taken from 9, then one added
// - word forms set error on any non-BCD nibble in either operand, else clear
// - word forms with all-BCD operands set equals when the 16-bit result is zero, else clear
// - every form with all-BCD operands sets carry on a borrow (negative difference), else clears it
// - double subtract treats word pairs, second word upper, as 8-digit values
// - double subtract sets error when any of the four words is not BCD
// - double subtract sets equals only when the whole 32-bit result is zero
// - negative double difference gives 10's complement and sets carry
// - word subtract with borrow also subtracts the current carry flag
// - execute every cycle while condition true, or once on its rising edge
// - double subtract with borrow subtracts pair and carry, 10's complement if negative
package bsu_pkg;

  typedef enum logic [1:0] {
    BSU_OP_WORD          = 2'h0,
    BSU_OP_DOUBLE        = 2'h1,
    BSU_OP_WORD_BORROW   = 2'h2,
    BSU_OP_DOUBLE_BORROW = 2'h3
  } bsu_op_t;

  localparam int          BSU_NIBBLE      = 4;
  localparam int          BSU_WORD_DIGITS = 4;
  localparam int          BSU_MAX_DIGITS  = 8;
  localparam logic [3:0]  BSU_DIGIT_MAX   = 4'h9;
  localparam logic [3:0]  BSU_RADIX       = 4'ha;
  localparam logic        BSU_FLAG_RESET  = 1'b0;

endpackage

// file: tb/bsu_seq_model.sv
// sequencer model that issues subtract requests and clear-carry ops
`timescale 1ns/1ps
`default_nettype none

module bsu_seq_model (
  input  wire logic             clk_i,
  output var  logic             exec_o,
  output var  logic             edge_mode_o,
  output var  bsu_pkg::bsu_op_t op_o,
  output var  logic [63:0]      opnd_o,
  output var  logic             clr_carry_o
);
  import bsu_pkg::*;

  initial begin
    {exec_o, edge_mode_o, clr_carry_o} = 3'h0;
    op_o = BSU_OP_WORD;
    opnd_o = 64'h0;
  end

  // operands as {min_hi, min_lo, sub_hi, sub_lo}; condition held for cycles edges
  task automatic issue(input bsu_op_t op, input logic [63:0] opnd, input int cycles,
                       input logic edge_m);
    @(posedge clk_i);
    #1;
    op_o = op;
    opnd_o = opnd;
    edge_mode_o = edge_m;
    exec_o = 1'b1;
    repeat (cycles) @(posedge clk_i);
    #1 exec_o = 1'b0;
  endtask

  // one-cycle clear before a fresh borrow chain
  task automatic clr;
    @(posedge clk_i);
    #1 clr_carry_o = 1'b1;
    @(posedge clk_i);
    #1 clr_carry_o = 1'b0;
  endtask
endmodule

`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the packed-BCD subtract unit
`timescale 1ns/1ps
`default_nettype none

module tb;
  import bsu_pkg::*;

  typedef struct packed {
    logic [1:0]  op;
    logic [63:0] opnd;
    logic [31:0] res;
    logic [2:0]  fl;
  } bsu_row_t;

  logic             CLK_I = 1'b0;
  logic             RST_N_I = 1'b0;
  wire logic        exec, edge_m, clr, er, eq, cy, done;
  wire bsu_op_t     op;
  wire logic [63:0] opnd;
  wire logic [15:0] rl, rh;
  int               mismatches = 0;
  int               samples_checked = 0;
  int               dones = 0;

  // flags column is {error, equals, carry}; rows run in order, carry chains on
  bsu_row_t rows [13] = '{
    '{2'h0, 64'h5555_1234_1111_2000, 32'h0000_9234, 3'h1},
    '{2'h0, 64'h0000_5000_0000_5000, 32'h0000_0000, 3'h2},
    '{2'h1, 64'h0958_3960_1707_2641, 32'h9251_1319, 3'h1},
    '{2'h2, 64'h0000_0100_0000_0099, 32'h9251_0000, 3'h2},
    '{2'h2, 64'h5555_0000_1111_0001, 32'h9251_9999, 3'h1},
    '{2'h3, 64'h0000_0000_0000_0000, 32'h9999_9999, 3'h1},
    '{2'h2, 64'h0000_4321_0000_4321, 32'h9999_9999, 3'h1},
    '{2'h1, 64'h1234_5678_1234_5678, 32'h0000_0000, 3'h2},
    '{2'h0, 64'h0000_12a4_0000_0001, 32'h0000_0000, 3'h6},
    '{2'h2, 64'hffff_0009_0000_0003, 32'h0000_0006, 3'h0},
    '{2'h1, 64'h0000_0000_00f0_0000, 32'h0000_0006, 3'h4},
    '{2'h3, 64'h1000_0000_0000_0001, 32'h0999_9999, 3'h0},
    '{2'h0, 64'h0000_0042_0000_0000, 32'h0999_0042, 3'h0}};

  bsu_seq_model seq (.clk_i(CLK_I), .exec_o(exec), .edge_mode_o(edge_m), .op_o(op),
                     .opnd_o(opnd), .clr_carry_o(clr));

  bsu_bcd_subtract_unit dut (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .EXEC_I(exec),
    .EDGE_MODE_I(edge_m), .OP_I(op), .MIN_HI_I(opnd[63:48]), .MIN_LO_I(opnd[47:32]),
    .SUB_HI_I(opnd[31:16]), .SUB_LO_I(opnd[15:0]), .CLR_CARRY_I(clr), .RES_LO_O(rl),
    .RES_HI_O(rh), .ERROR_O(er), .EQUAL_O(eq), .CARRY_O(cy), .DONE_O(done));

  always #5 CLK_I = ~CLK_I;

  always @(posedge CLK_I) begin
    if (done === 1'b1) dones++;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge CLK_I);
    #1 RST_N_I = 1'b1;
    chk({rh, rl}, 32'h0);
    chk({28'h0, er, eq, cy, done}, 32'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      seq.issue(bsu_op_t'(rows[i].op), rows[i].opnd, 1, 1'b0);
      chk({rh, rl}, rows[i].res);
      chk({28'h0, er, eq, cy, done}, {28'h0, rows[i].fl, 1'b1});
    end
    $display("test table done");
    @(posedge CLK_I);
    #1 dones = 0;
    seq.issue(BSU_OP_WORD, 64'h0000_1234_0000_2000, 3, 1'b1);
    repeat (2) @(posedge CLK_I);
    #1;
    chk(dones, 32'd1);
    chk({31'h0, cy}, 32'h1);
    seq.clr;
    chk({31'h0, cy}, 32'h0);
    dones = 0;
    seq.issue(BSU_OP_WORD, 64'h0000_0007_0000_0002, 3, 1'b0);
    repeat (2) @(posedge CLK_I);
    #1;
    chk(dones, 32'd3);
    chk({16'h0, rl}, 32'h0000_0005);
    $display("test modes done");
    @(posedge CLK_I);
    #1 RST_N_I = 1'b0;
    repeat (2) @(posedge CLK_I);
    #1 RST_N_I = 1'b1;
    chk({rh, rl}, 32'h0);
    chk({28'h0, er, eq, cy, done}, 32'h0);
    $display("test reset again done");
    wrap_up;
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    #50000;
    mismatches++;
    wrap_up;
  end
endmodule

`default_nettype wire

// file: verilog/bsu_bcd_subtract_unit.sv
// packed-BCD subtract datapath: word, double word and borrow-in forms
`timescale 1ns/1ps
`default_nettype none

module bsu_bcd_subtract_unit #(
  parameter int WORD_DIGITS = bsu_pkg::BSU_WORD_DIGITS
) (
  input  wire logic                              CLK_I,
  input  wire logic                              RST_N_I,
  input  wire logic                              EXEC_I,
  input  wire logic                              EDGE_MODE_I,
  input  wire bsu_pkg::bsu_op_t                  OP_I,
  input  wire logic [4*WORD_DIGITS-1:0]          MIN_LO_I,
  input  wire logic [4*WORD_DIGITS-1:0]          MIN_HI_I,
  input  wire logic [4*WORD_DIGITS-1:0]          SUB_LO_I,
  input  wire logic [4*WORD_DIGITS-1:0]          SUB_HI_I,
  input  wire logic                              CLR_CARRY_I,
  output logic      [4*WORD_DIGITS-1:0]          RES_LO_O,
  output logic      [4*WORD_DIGITS-1:0]          RES_HI_O,
  output logic                                   ERROR_O,
  output logic                                   EQUAL_O,
  output logic                                   CARRY_O,
  output logic                                   DONE_O
);
  import bsu_pkg::*;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  localparam int W  = BSU_NIBBLE * WORD_DIGITS;
  localparam int ND = 2 * WORD_DIGITS;

  // the double forms need twice the word digits within the supported span
  if (WORD_DIGITS < 1 || 2 * WORD_DIGITS > BSU_MAX_DIGITS) begin : g_bad_digits
    $error("WORD_DIGITS out of range");
  end

  typedef struct packed {
    logic [W-1:0] res_lo;
    logic [W-1:0] res_hi;
    logic         err;
    logic         eq;
    logic         carry;
    logic         cond_prev;
    logic         done;
  } bsu_state_t;

  bsu_state_t st_r;
  bsu_state_t st_nxt;

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic bsu_bcd_ok(input logic [W-1:0] w);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < WORD_DIGITS; i++) begin
      if (w[BSU_NIBBLE*i +: BSU_NIBBLE] > BSU_DIGIT_MAX) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  logic          fire;
  logic          is_double;
  logic          uses_borrow;
  logic          word_ok;
  logic          dbl_ok;
  logic          in_ok;
  logic [2*W-1:0] diff;
  logic          borrow_word;
  logic          borrow_dbl;

  // level mode runs each cycle, edge mode only on the rising edge
  assign fire        = EXEC_I && (!EDGE_MODE_I || !st_r.cond_prev);
  assign is_double   = (OP_I == BSU_OP_DOUBLE) || (OP_I == BSU_OP_DOUBLE_BORROW);
  assign uses_borrow = (OP_I == BSU_OP_WORD_BORROW) || (OP_I == BSU_OP_DOUBLE_BORROW);
  assign word_ok     = bsu_bcd_ok(MIN_LO_I) && bsu_bcd_ok(SUB_LO_I);
  assign dbl_ok      = word_ok && bsu_bcd_ok(MIN_HI_I) && bsu_bcd_ok(SUB_HI_I);
  assign in_ok       = is_double ? dbl_ok : word_ok;

  //////////////////////////////////////////////////////////////////////////////
  // digit-serial decimal subtract over both words

  // a borrow-propagating decimal subtract yields the difference modulo 10^n,
  // which for a negative result is exactly the 9s-complement-plus-one form
  always_comb begin
    logic [4:0] t;
    logic       br;
    t           = 5'h00;
    br          = uses_borrow ? st_r.carry : 1'b0;
    diff        = '0;
    borrow_word = 1'b0;
    for (int i = 0; i < ND; i++) begin
      if (i < WORD_DIGITS) begin
        t = {1'b0, MIN_LO_I[BSU_NIBBLE*i +: BSU_NIBBLE]}
          - {1'b0, SUB_LO_I[BSU_NIBBLE*i +: BSU_NIBBLE]} - {4'h0, br};
      end else begin
        t = {1'b0, MIN_HI_I[BSU_NIBBLE*(i-WORD_DIGITS) +: BSU_NIBBLE]}
          - {1'b0, SUB_HI_I[BSU_NIBBLE*(i-WORD_DIGITS) +: BSU_NIBBLE]} - {4'h0, br};
      end
      if (t[4]) begin
        diff[BSU_NIBBLE*i +: BSU_NIBBLE] = t[3:0] + BSU_RADIX;
        br = 1'b1;
      end else begin
        diff[BSU_NIBBLE*i +: BSU_NIBBLE] = t[3:0];
        br = 1'b0;
      end
      if (i == WORD_DIGITS - 1) begin
        borrow_word = br;
      end
    end
    borrow_dbl = br;
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_nxt           = st_r;
    st_nxt.cond_prev = EXEC_I;
    st_nxt.done      = fire;
    if (fire) begin
      st_nxt.err = !in_ok;
      if (in_ok) begin
        st_nxt.res_lo = diff[W-1:0];
        if (is_double) begin
          st_nxt.res_hi = diff[2*W-1:W];
          st_nxt.eq     = (diff == '0);
          st_nxt.carry  = borrow_dbl;
        end else begin
          st_nxt.eq    = (diff[W-1:0] == '0);
          st_nxt.carry = borrow_word;
        end
      end
      // invalid input leaves result, equals and carry alone
    end else if (CLR_CARRY_I) begin
      st_nxt.carry = BSU_FLAG_RESET;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign RES_LO_O = st_r.res_lo;
  assign RES_HI_O = st_r.res_hi;
  assign ERROR_O  = st_r.err;
  assign EQUAL_O  = st_r.eq;
  assign CARRY_O  = st_r.carry;
  assign DONE_O   = st_r.done;

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence s_fire_word_ok;
    fire && word_ok && (OP_I == BSU_OP_WORD);
  endsequence

  sequence s_fire_dbl_ok;
    fire && dbl_ok && (OP_I == BSU_OP_DOUBLE);
  endsequence

  sequence s_held_high;
    EDGE_MODE_I && EXEC_I ##1 EDGE_MODE_I && EXEC_I;
  endsequence

  property p_err_word;
    fire && !is_double && !word_ok |=> ERROR_O;
  endproperty
  a_err_word: assert property (p_err_word) else $error("word error flag not set");

  property p_err_dbl;
    fire && is_double |=> ERROR_O == !$past(dbl_ok);
  endproperty
  a_err_dbl: assert property (p_err_dbl) else $error("double error flag wrong");

  property p_hold_on_err;
    fire && !in_ok |=> $stable(RES_LO_O) && $stable(RES_HI_O) && $stable(EQUAL_O)
                       && $stable(CARRY_O);
  endproperty
  a_hold_on_err: assert property (p_hold_on_err) else $error("state moved on bad input");

  property p_eq_word;
    s_fire_word_ok |=> EQUAL_O == (RES_LO_O == '0);
  endproperty
  a_eq_word: assert property (p_eq_word) else $error("word equals flag wrong");

  property p_eq_dbl;
    s_fire_dbl_ok |=> EQUAL_O == ({RES_HI_O, RES_LO_O} == '0);
  endproperty
  a_eq_dbl: assert property (p_eq_dbl) else $error("double equals flag wrong");

  property p_carry_word;
    s_fire_word_ok |=> CARRY_O == ($past(MIN_LO_I) < $past(SUB_LO_I));
  endproperty
  a_carry_word: assert property (p_carry_word) else $error("word carry wrong");

  property p_carry_dbl;
    s_fire_dbl_ok |=> CARRY_O == ({$past(MIN_HI_I), $past(MIN_LO_I)}
                                  < {$past(SUB_HI_I), $past(SUB_LO_I)});
  endproperty
  a_carry_dbl: assert property (p_carry_dbl) else $error("double carry wrong");

  property p_same_zero;
    s_fire_word_ok ##0 (MIN_LO_I == SUB_LO_I) |=> (RES_LO_O == '0) && !CARRY_O && EQUAL_O;
  endproperty
  a_same_zero: assert property (p_same_zero) else $error("equal operands not zero");

  property p_borrow_in;
    fire && word_ok && (OP_I == BSU_OP_WORD_BORROW) && st_r.carry
      && (MIN_LO_I == SUB_LO_I) |=> CARRY_O && !EQUAL_O;
  endproperty
  a_borrow_in: assert property (p_borrow_in) else $error("borrow-in ignored");

  property p_edge_once;
    s_held_high |=> !DONE_O;
  endproperty
  a_edge_once: assert property (p_edge_once) else $error("edge mode fired twice");

  property p_level_each;
    !EDGE_MODE_I && EXEC_I |=> DONE_O;
  endproperty
  a_level_each: assert property (p_level_each) else $error("level mode missed a cycle");

  property p_clear_carry;
    CLR_CARRY_I && !fire |=> !CARRY_O;
  endproperty
  a_clear_carry: assert property (p_clear_carry) else $error("carry not cleared");

  // borrow-in forms take the carry flag held before the executing edge
  sequence s_fire_wb_ok;
    fire && word_ok && (OP_I == BSU_OP_WORD_BORROW);
  endsequence

  sequence s_fire_db_ok;
    fire && dbl_ok && (OP_I == BSU_OP_DOUBLE_BORROW);
  endsequence

  property p_carry_wb;
    s_fire_wb_ok |=> CARRY_O == ({1'b0, $past(MIN_LO_I)}
                                 < {1'b0, $past(SUB_LO_I)} + $past(CARRY_O));
  endproperty
  a_carry_wb: assert property (p_carry_wb) else $error("word borrow-in carry wrong");

  property p_eq_wb;
    s_fire_wb_ok |=> EQUAL_O == (RES_LO_O == '0);
  endproperty
  a_eq_wb: assert property (p_eq_wb) else $error("word borrow-in equals wrong");

  property p_carry_db;
    s_fire_db_ok |=> CARRY_O == ({1'b0, $past(MIN_HI_I), $past(MIN_LO_I)}
                                 < {1'b0, $past(SUB_HI_I), $past(SUB_LO_I)} + $past(CARRY_O));
  endproperty
  a_carry_db: assert property (p_carry_db) else $error("double borrow-in carry wrong");

  property p_eq_db;
    s_fire_db_ok |=> EQUAL_O == ({RES_HI_O, RES_LO_O} == '0);
  endproperty
  a_eq_db: assert property (p_eq_db) else $error("double borrow-in equals wrong");

  // word forms and results that stand between executions
  property p_err_clr_word;
    fire && !is_double && word_ok |=> !ERROR_O;
  endproperty
  a_err_clr_word: assert property (p_err_clr_word) else $error("word error not cleared");

  property p_hi_kept;
    fire && !is_double |=> $stable(RES_HI_O);
  endproperty
  a_hi_kept: assert property (p_hi_kept) else $error("word form wrote upper result");

  property p_zero_sub;
    s_fire_word_ok ##0 (SUB_LO_I == '0) |=> (RES_LO_O == $past(MIN_LO_I)) && !CARRY_O;
  endproperty
  a_zero_sub: assert property (p_zero_sub) else $error("zero subtrahend changed value");

  property p_bcd_res;
    fire && in_ok |=> bsu_bcd_ok(RES_LO_O) && bsu_bcd_ok(RES_HI_O);
  endproperty
  a_bcd_res: assert property (p_bcd_res) else $error("result holds a non-BCD digit");

  property p_stand;
    !fire && !CLR_CARRY_I |=> $stable(RES_LO_O) && $stable(RES_HI_O) && $stable(ERROR_O)
                              && $stable(EQUAL_O) && $stable(CARRY_O);
  endproperty
  a_stand: assert property (p_stand) else $error("state moved without execution");

  // execution follows the input condition
  sequence s_exec_rise;
    !EXEC_I ##1 EXEC_I && EDGE_MODE_I;
  endsequence

  property p_edge_first;
    s_exec_rise |=> DONE_O;
  endproperty
  a_edge_first: assert property (p_edge_first) else $error("edge mode missed the rise");

  property p_no_cond;
    !EXEC_I |=> !DONE_O;
  endproperty
  a_no_cond: assert property (p_no_cond) else $error("executed without condition");

endmodule

`default_nettype wire
